// File: rtl/lcdcfg_top.v
// Purpose: Register front end and common/segment pin routing of a segment display driver.
// Assumes: APB slave on mclk, single clock, synchronous active-low reset.
// Notes: Common/segment levels are logical phase bits; analog drive lies outside.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "lcdcfg_consts.vh"

module lcdcfg_top (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // System state
  input wire standby,
  input wire [31:0] port_out,
  // Panel side
  output reg [3:0] com_out,
  output reg [3:0] com_active,
  output reg [31:0] seg_out,
  output reg [31:0] seg_is_segment,
  output reg wave_b,
  output reg drive_power_on
);

  // ============================================================
  // Registers
  reg [7:0] pin_ctrl_r;
  reg [7:0] disp_ctrl_r;
  reg [7:0] wave_ctrl_r;
  reg [7:0] clk_gate_r;
  reg [7:0] ram_r [0:31];
  reg [`LC_DIV_W-1:0] div_r;
  reg [1:0] phase_r;
  reg frame_pol_r;
  reg standby_s1_r;
  reg standby_s2_r;

  wire [15:0] addr = paddr[15:0];
  wire wr_en = psel & penable & pwrite;
  wire ram_hit = (addr >= `LC_RAM_BASE) && (addr <= `LC_RAM_LAST);
  wire [4:0] ram_idx = addr[4:0] & 5'h1C;
  wire [15:0] word_addr = {addr[15:2], 2'h0};
  wire duty_hi = pin_ctrl_r[`LC_DUTY_HI];
  wire duty_lo = pin_ctrl_r[`LC_DUTY_LO];
  wire [1:0] duty = {duty_hi, duty_lo};
  wire mirror = pin_ctrl_r[`LC_MIRROR];
  wire gate_open = clk_gate_r[`LC_GATE_BIT];
  wire active_bit = disp_ctrl_r[`LC_ACT];
  wire pwr_req = disp_ctrl_r[`LC_PWR_ON];
  wire running = active_bit & gate_open & ~standby_s2_r;

  // Control register aligned in the byte lane of its address.
  function [7:0] lane_byte;
    input [31:0] d;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: lane_byte = d[7:0];
        2'h1: lane_byte = d[15:8];
        2'h2: lane_byte = d[23:16];
        default: lane_byte = d[31:24];
      endcase
    end
  endfunction

  function ctl_wr;
    input [15:0] a;
    input [15:0] reg_addr;
    input [3:0] strb;
    begin
      ctl_wr = (a[15:2] == reg_addr[15:2]) && strb[reg_addr[1:0]];
    end
  endfunction

  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ============================================================
  // Standby synchroniser
  // Standby comes from another clock domain; only the second stage feeds logic, so a
  // metastable first stage can never reach the display timing.
  always @(posedge mclk) begin
    if (!rst_n) begin
      standby_s1_r <= 1'b0;
      standby_s2_r <= 1'b0;
    end else begin
      standby_s1_r <= standby;
      standby_s2_r <= standby_s1_r;
    end
  end

  // ============================================================
  // Register writes
  always @(posedge mclk) begin
    if (!rst_n) begin
      pin_ctrl_r <= `LC_PIN_RST;
      disp_ctrl_r <= `LC_DISP_RST;
      wave_ctrl_r <= `LC_WAVE_RST;
      clk_gate_r <= `LC_GATE_RST;
    end else if (wr_en) begin
      // Reserved bits of the pin, display and wave bytes are forced here, so a stray write cannot change what they read.
      if (ctl_wr(addr, `LC_PIN_CTRL, pstrb))
        pin_ctrl_r <= lane_byte(pwdata, `LC_LANE_PIN) & `LC_PIN_WMASK;
      if (ctl_wr(addr, `LC_DISP_CTRL, pstrb))
        disp_ctrl_r <= lane_byte(pwdata, `LC_LANE_DISP) | `LC_DISP_ONES;
      if (ctl_wr(addr, `LC_WAVE_CTRL, pstrb))
        wave_ctrl_r <= (lane_byte(pwdata, `LC_LANE_WAVE) & `LC_WAVE_WMASK) | `LC_WAVE_ONES;
      if (ctl_wr(addr, `LC_CLK_GATE, pstrb))
        clk_gate_r <= lane_byte(pwdata, `LC_LANE_GATE);
    end
  end

  // Display RAM: no reset, byte lanes allow byte and word writes.
  always @(posedge mclk) begin
    if (wr_en && ram_hit) begin
      if (pstrb[0]) ram_r[ram_idx] <= pwdata[7:0];
      if (pstrb[1]) ram_r[ram_idx + 5'h1] <= pwdata[15:8];
      if (pstrb[2]) ram_r[ram_idx + 5'h2] <= pwdata[23:16];
      if (pstrb[3]) ram_r[ram_idx + 5'h3] <= pwdata[31:24];
    end
  end

  // ============================================================
  // Read path: zero-wait, unmapped reads return zero.
  // Read data is captured at the end of the setup cycle, so it stands from a flip-flop for
  // the whole access cycle; only bus writes move the registers, and none falls between.
  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h0;
    if (ram_hit) begin
      rd_word = {ram_r[ram_idx + 5'h3], ram_r[ram_idx + 5'h2],
                 ram_r[ram_idx + 5'h1], ram_r[ram_idx]};
    end else begin
      case (word_addr)
        `LC_PIN_WORD: begin
          rd_word = {8'h0, wave_ctrl_r, disp_ctrl_r, pin_ctrl_r};
        end
        `LC_GATE_WORD: begin
          rd_word = {clk_gate_r, 24'h0};
        end
        default: begin
          rd_word = 32'h0;
        end
      endcase
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= rd_word;
    end
  end

  // ============================================================
  // Frame timing: divider tap from the four select bits gives nine rates.
  function [3:0] frame_tap;
    input [3:0] cks;
    begin
      if (!cks[3])
        frame_tap = cks[1] ? 4'h2 : {3'h0, cks[0]};
      else
        frame_tap = {1'b0, cks[2:0]} + 4'h1;
    end
  endfunction

  // The frame polarity is held while the display is stopped, so segments freeze at one
  // level instead of flickering when the controller restarts.
  wire [3:0] frame_sel = disp_ctrl_r[`LC_CKS_HI:`LC_CKS_LO];
  wire [3:0] tap = frame_tap(frame_sel);
  wire [`LC_DIV_W:0] div_ext = {1'b0, div_r} + {{`LC_DIV_W{1'b0}}, 1'b1};
  wire step = (div_r[tap] == 1'b1) && (div_ext[tap] == 1'b0);
  wire [1:0] last_phase = duty;

  always @(posedge mclk) begin
    if (!rst_n) begin
      div_r <= {`LC_DIV_W{1'b0}};
      phase_r <= 2'h0;
      frame_pol_r <= 1'b0;
    end else if (running) begin
      div_r <= div_ext[`LC_DIV_W-1:0];
      if (step) begin
        if (phase_r >= last_phase) begin
          phase_r <= 2'h0;
          frame_pol_r <= ~frame_pol_r;
        end else begin
          phase_r <= phase_r + 2'h1;
        end
        if (!wave_ctrl_r[`LC_WAVE_B] && phase_r < last_phase)
          frame_pol_r <= ~frame_pol_r;
      end
    end else begin
      div_r <= {`LC_DIV_W{1'b0}};
      phase_r <= 2'h0;
    end
  end

  // ============================================================
  // Common routing
  // A mirrored common gets the select pattern of its partner, so both carry one waveform.
  reg [3:0] act_nxt;
  reg [3:0] sel_nxt;
  always @* begin
    case (duty)
      `LC_DUTY_STATIC: begin
        act_nxt = mirror ? 4'hF : 4'h1;
        sel_nxt = mirror ? 4'hF : 4'h1;
      end
      `LC_DUTY_HALF: begin
        act_nxt = mirror ? 4'hF : 4'h3;
        sel_nxt = (phase_r == 2'h0) ? (mirror ? 4'h3 : 4'h1) : (mirror ? 4'hC : 4'h2);
      end
      `LC_DUTY_THIRD: begin
        act_nxt = 4'h7;
        sel_nxt = 4'h1 << phase_r;
      end
      default: begin
        act_nxt = 4'hF;
        sel_nxt = 4'h1 << phase_r;
      end
    endcase
  end

  // The non-selecting level of an unused common is low, so a common that the duty leaves
  // idle never carries a waveform that could half-select a panel row.
  reg [3:0] com_nxt;
  always @* begin
    com_nxt = 4'h0;
    if (running) begin
      com_nxt = (sel_nxt & act_nxt & {4{~frame_pol_r}}) |
                (~sel_nxt & act_nxt & {4{frame_pol_r}});
    end
  end

  // Segment groups are handed over from the top pin down, eight pins at a time.
  function [31:0] seg_group_mask;
    input [3:0] sgs;
    begin
      casez (sgs)
        4'b1???: seg_group_mask = 32'hFFFFFFFF;
        4'b011?: seg_group_mask = 32'hFFFFFF00;
        4'b010?: seg_group_mask = 32'hFFFF0000;
        4'b001?: seg_group_mask = 32'hFF000000;
        default: seg_group_mask = 32'h00000000;
      endcase
    end
  endfunction

  wire [7:0] ram_byte = ram_r[{3'h0, phase_r}];
  wire show = disp_ctrl_r[`LC_DISP_EN];
  wire [31:0] seg_mask = seg_group_mask(pin_ctrl_r[`LC_SGS_HI:`LC_SGS_LO]);

  integer i;
  always @(posedge mclk) begin
    if (!rst_n) begin
      com_out <= 4'h0;
      com_active <= 4'h0;
      seg_out <= 32'h0;
      seg_is_segment <= 32'h0;
      wave_b <= 1'b0;
      drive_power_on <= 1'b0;
    end else begin
      wave_b <= wave_ctrl_r[`LC_WAVE_B];
      drive_power_on <= running & pwr_req;
      com_active <= running ? act_nxt : 4'h0;
      com_out <= com_nxt;
      for (i = 0; i < 32; i = i + 1) begin
        if (seg_mask[i]) begin
          seg_is_segment[i] <= 1'b1;
          seg_out[i] <= running & show & ram_byte[i % 8] ^ frame_pol_r;
        end else begin
          seg_is_segment[i] <= 1'b0;
          seg_out[i] <= port_out[i];
        end
      end
    end
  end

endmodule

// File: rtl/lcdcfg_consts.vh
// Purpose: Constants for the segment display configuration block.
// Assumes: APB with 32-bit data, word-aligned registers.
// Notes: Definitions only.
`ifndef LCDCFG_CONSTS_VH
`define LCDCFG_CONSTS_VH
// ============================================================
// Register map (byte addresses, low 16 bits)
`define LC_RAM_BASE 16'hF740
`define LC_RAM_LAST 16'hF75F
`define LC_PIN_CTRL 16'hFFC0
`define LC_DISP_CTRL 16'hFFC1
`define LC_WAVE_CTRL 16'hFFC2
`define LC_CLK_GATE 16'hFFFB
`define LC_PIN_WORD 16'hFFC0
`define LC_GATE_WORD 16'hFFF8
// ============================================================
// Byte lanes of the control words
`define LC_LANE_PIN 2'h0
`define LC_LANE_DISP 2'h1
`define LC_LANE_WAVE 2'h2
`define LC_LANE_GATE 2'h3
// ============================================================
// Reset values and fixed bits
`define LC_PIN_RST 8'h00
`define LC_DISP_RST 8'h80
`define LC_WAVE_RST 8'h60
`define LC_GATE_RST 8'hFF
`define LC_PIN_WMASK 8'hEF
`define LC_DISP_ONES 8'h80
`define LC_WAVE_WMASK 8'h8F
`define LC_WAVE_ONES 8'h60
// ============================================================
// Field positions
`define LC_DUTY_HI 7
`define LC_DUTY_LO 6
`define LC_MIRROR 5
`define LC_ACT 5
`define LC_DISP_EN 4
`define LC_PWR_ON 6
`define LC_CKS_HI 3
`define LC_CKS_LO 0
`define LC_SGS_HI 3
`define LC_SGS_LO 0
`define LC_WAVE_B 7
`define LC_GATE_BIT 0
// ============================================================
// Duty encodings
`define LC_DUTY_STATIC 2'h0
`define LC_DUTY_HALF 2'h1
`define LC_DUTY_THIRD 2'h2
`define LC_DUTY_QUARTER 2'h3
// Frame clock divider
`define LC_FRAME_NUM 11
`define LC_DIV_W 9
`endif

// File: sim/lcdcfg_properties.sv
// Purpose: Port-level assertions for the display configuration block.
// Assumes: Pin control is written as lane 0 of the word at FFC0.
// Notes: The duty-commons and static-mirror checks apply only while the commons are being driven; the half and third checks always apply.
`timescale 1ns/1ps
module lcdcfg_props (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire pready,
  input wire pslverr,
  // System and panel
  input wire standby,
  input wire [31:0] port_out,
  input wire [3:0] com_out,
  input wire [3:0] com_active,
  input wire [31:0] seg_out,
  input wire [31:0] seg_is_segment,
  input wire drive_power_on
);
  // ============================================================
  // Shadow of the pin control byte
  reg [7:0] pc_r;
  wire wr_pc = psel & penable & pwrite & pready & (paddr[15:0] == 16'hFFC0) & pstrb[0];
  always @(posedge mclk) begin
    if (!rst_n) pc_r <= 8'h00;
    else if (wr_pc) pc_r <= pwdata[7:0];
  end
  function [3:0] act_f(input [7:0] p);
    case (p[7:6])
      2'h0: act_f = p[5] ? 4'hF : 4'h1;
      2'h1: act_f = p[5] ? 4'hF : 4'h3;
      2'h2: act_f = 4'h7;
      default: act_f = 4'hF;
    endcase
  endfunction
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_duty_commons: assert property ((com_active != 4'h0) |-> com_active == act_f($past(pc_r)))
    else $error("active commons do not match duty");
  a_static_mirror: assert property (($past(pc_r[7:5]) == 3'h1 && com_active != 4'h0)
    |-> com_out == {4{com_out[0]}}) else $error("static mirror commons differ");
  a_half_plain: assert property (($past(pc_r[7:5]) == 3'h2) |-> com_active[3:2] == 2'h0)
    else $error("half duty drives upper commons");
  a_half_mirror: assert property (($past(pc_r[7:5]) == 3'h3)
    |-> com_out[3] == com_out[2] && com_out[1] == com_out[0]) else $error("half mirror differs");
  a_third_four: assert property (($past(pc_r[7:6]) == 2'h2) |-> !com_active[3])
    else $error("third duty drives common four");
  a_seg_groups: assert property ((seg_is_segment != 32'h0) |-> seg_is_segment ==
    ($past(pc_r[3]) ? 32'hFFFFFFFF : ~(32'hFFFFFFFF >> (8 * $past(pc_r[2:1])))))
    else $error("segment group mapping wrong");
  a_port_pins: assert property (((seg_out ^ $past(port_out)) & ~seg_is_segment) == 32'h0)
    else $error("port pin level wrong");
  a_standby_stop: assert property (standby [*5] |-> com_active == 4'h0 && !drive_power_on)
    else $error("display runs in standby");
  a_unused_idle: assert property ((com_out & ~com_active) == 4'h0)
    else $error("unused common toggles");
  c_quarter: cover property (com_active == 4'hF);
  c_all_seg: cover property (seg_is_segment == 32'hFFFFFFFF);
  c_pc_write: cover property (wr_pc);
endmodule
bind lcdcfg_top lcdcfg_props u_props (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .standby(standby), .port_out(port_out),
  .com_out(com_out), .com_active(com_active), .seg_out(seg_out),
  .seg_is_segment(seg_is_segment), .drive_power_on(drive_power_on));

// File: sim/lcdcfg_panel.sv
// Purpose: Panel model that records which commons carried a waveform.
// Assumes: Common phase bits change only on driven commons.
// Notes: A common that never moves would leave its panel rows dark.
`timescale 1ns/1ps
module lcdcfg_panel (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Common lines
  input wire [3:0] com_out,
  input wire [3:0] com_active,
  // Observed activity
  output reg [3:0] seen
);
  // ============================================================
  // Toggle record
  reg [3:0] last_r;
  always @(posedge mclk) begin
    if (!rst_n) begin
      seen <= 4'h0;
      last_r <= 4'h0;
    end else begin
      seen <= seen | ((com_out ^ last_r) & com_active);
      last_r <= com_out;
    end
  end
endmodule

// File: sim/tb.sv
// Purpose: Self-checking bench for the display configuration block.
// Assumes: Zero-wait APB slave; register outputs settle within three edges.
// Notes: Frame rate set to divider tap 1, the second fastest, so commons move in a short run.
`timescale 1ns/1ps
module tb;
  // ============================================================
  // Signals and helpers
  reg mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, standby = 0;
  reg [31:0] paddr = 0, pwdata = 0, port_out = 0;
  reg [3:0] pstrb = 0;
  reg [7:0] p;
  wire pready, pslverr, wave_b, drive_power_on;
  wire [31:0] prdata, seg_out, seg_is_segment;
  wire [3:0] com_out, com_active, seen;
  integer failures = 0, n_compared = 0, i;
  always #50 mclk = ~mclk;
  lcdcfg_top DUT (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .standby(standby), .port_out(port_out),
    .com_out(com_out), .com_active(com_active), .seg_out(seg_out),
    .seg_is_segment(seg_is_segment), .wave_b(wave_b), .drive_power_on(drive_power_on));
  lcdcfg_panel u_panel (.mclk(mclk), .rst_n(rst_n), .com_out(com_out), .com_active(com_active),
    .seen(seen));
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task apb(input w, input [15:0] a, input [31:0] d, input [3:0] s, output [31:0] q);
    begin
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {16'h0000, a};
      pwdata <= d;
      pstrb <= s;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      q = prdata;
      chk("pslverr", 32'h0, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [15:0] a, input [31:0] d, input [3:0] s);
    reg [31:0] q;
    begin
      apb(1'b1, a, d, s, q);
      repeat (3) @(posedge mclk);
    end
  endtask
  task rd(input [15:0] a, input [31:0] e);
    reg [31:0] q;
    begin
      apb(1'b0, a, 32'h00000000, 4'hF, q);
      chk("prdata", e, q);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    #(100 * 20000);
    failures = failures + 1;
    summarize;
  end
  // ============================================================
  // Tests
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd(16'hFFC0, 32'h00608000);
    rd(16'hFFF8, 32'hFF000000);
    rd(16'h1000, 32'h00000000);
    wr(16'hFFC0, 32'h00006800, 4'h2);
    for (i = 0; i < 16; i = i + 1) begin
      p = {i[2:0], 1'b0, i[3:0]};
      wr(16'hFFC0, {24'h0, p}, 4'h1);
      chk("com_active", 32'hFF77F3F1 >> (4 * i[2:0]) & 32'hF, com_active);
      chk("seg_sel", p[3] ? 32'hFFFFFFFF : ~(32'hFFFFFFFF >> (8 * p[2:1])), seg_is_segment);
      rd(16'hFFC0, {16'h0060, 8'hE8, p});
    end
    repeat (3000) @(posedge mclk);
    chk("panel", 32'hF, seen);
    port_out <= 32'hA5A5A5A5;
    wr(16'hFFC0, 32'h00000002, 4'h1);
    chk("port_pins", 32'h00A5A5A5, seg_out & ~seg_is_segment);
    wr(16'hFFC0, 32'h00800000, 4'h4);
    chk("wave_b", 32'h1, wave_b);
    rd(16'hFFC0, 32'h00E0E802);
    wr(16'hF740, 32'h12345678, 4'hF);
    wr(16'hF75C, 32'hCAFEF00D, 4'hF);
    wr(16'hF75C, 32'h0000AB00, 4'h2);
    rd(16'hF75C, 32'hCAFEAB0D);
    rd(16'hF740, 32'h12345678);
    wr(16'hFFF8, 32'hFE000000, 4'h8);
    chk("gated", 32'h0, com_active);
    wr(16'hFFF8, 32'hFF000000, 4'h8);
    chk("ungated", 32'h1, com_active);
    chk("power_on", 32'h1, {31'h0, drive_power_on});
    standby <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("standby", 32'h0, {drive_power_on, com_active});
    standby <= 1'b0;
    summarize;
  end
endmodule
